// file: hw/wwdt_top.sv
/*
 * Windowed watchdog timer with APB register access.
 * Assumes: both oscillator inputs are slow square waves from other
 * clock domains, synchronised here, the selected one edge-detected on pclk;
 * chip_reset_req is held by the chip's reset logic, which then asserts
 * presetn; wdt_reset_seen is a level from the always-on reset logic,
 * also from another domain and synchronised here.
 */
`timescale 1ns/100ps
module wwdt_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic internal_rc_oscillator,
    input wire logic dedicated_watchdog_oscillator,
    input wire logic wdt_reset_seen,
    output logic chip_reset_req,
    output logic irq
);
    // ==========================================================
    // Oscillator synchronisers and count-edge detect
    logic [1:0] irc_sync_r;
    logic [1:0] wdo_sync_r;
    logic clk_sel_r;
    logic cnt_clk_prev_r;
    logic watchdog_count_clock;
    logic count_tick;

    // Two flops each; only the second stage is read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irc_sync_r <= 2'h0;
            wdo_sync_r <= 2'h0;
        end
        else
        begin
            irc_sync_r <= {irc_sync_r[0], internal_rc_oscillator};
            wdo_sync_r <= {wdo_sync_r[0], dedicated_watchdog_oscillator};
        end
    end

    // Reset-cause level arrives from the always-on domain; two flops
    // before the flag reads it, like the oscillators
    logic [1:0] seen_sync_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seen_sync_r <= 2'h0;
        else
            seen_sync_r <= {seen_sync_r[0], wdt_reset_seen};
    end

    // Source mux after synchronising, so a switch cannot glitch a flop
    assign watchdog_count_clock = clk_sel_r ? wdo_sync_r[1]
                                            : irc_sync_r[1];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_clk_prev_r <= 1'b0;
        else
            cnt_clk_prev_r <= watchdog_count_clock;
    end

    // Rising edge of the chosen, synchronised counting clock
    assign count_tick = watchdog_count_clock & ~cnt_clk_prev_r;

    // ==========================================================
    // APB decode
    localparam int ST_W = wwdt_pkg::ST_WIDTH;
    logic wr_en;
    logic en_r;
    logic reset_mode_r;
    logic window_mode_r;
    logic rcause_r;
    logic [23:0] tc_r;
    logic [23:0] cnt_r;
    logic [1:0] presc_r;
    logic [9:0] warn_r;
    logic [23:0] window_r;
    logic [ST_W-1:0] status_r;
    logic [ST_W-1:0] mask_r;
    logic feed_armed_r;
    logic feed_ok;
    logic feed_bad;
    logic feed_early;
    logic timeout_ev;
    logic warn_ev;
    logic [ST_W-1:0] events;
    logic any_fault;

    assign wr_en = psel & penable & pwrite;

    // Write strobe of one register; mode, feed, status and mask decode it this way
    function automatic logic reg_wr(input logic we, input logic [7:0] a,
        input logic [7:0] offs);
        reg_wr = we && a == offs;
    endfunction : reg_wr
    // Zero wait states; unmapped offsets read zero with no error
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // ==========================================================
    // Mode register: writes only set enable and reset mode; a fault in interrupt response clears enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_r <= 1'b0;
            reset_mode_r <= 1'b0;
            window_mode_r <= 1'b0;
        end
        else if (any_fault && !reset_mode_r)
            en_r <= 1'b0; // Fault in interrupt response ends the watchdog
        else if (reg_wr(wr_en, paddr, wwdt_pkg::ADDR_MODE))
        begin
            en_r <= en_r | pwdata[wwdt_pkg::MODE_EN_BIT];
            reset_mode_r <= reset_mode_r
                            | pwdata[wwdt_pkg::MODE_RESET_BIT];
            window_mode_r <= pwdata[wwdt_pkg::MODE_WINDOW_BIT];
        end
    end

    // Reset-cause flag caught after release; software writes 1 to clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rcause_r <= 1'b0;
        else if (seen_sync_r[1])
            rcause_r <= 1'b1;
        else if (reg_wr(wr_en, paddr, wwdt_pkg::ADDR_MODE)
                 && pwdata[wwdt_pkg::MODE_RCAUSE_BIT])
            rcause_r <= 1'b0;
    end

    // Timing constants; time-out below 255 counts is raised to it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tc_r <= wwdt_pkg::TC_RESET;
            warn_r <= wwdt_pkg::WARN_RESET;
            window_r <= wwdt_pkg::WINDOW_RESET;
            clk_sel_r <= 1'b0;
        end
        else if (wr_en)
        begin
            if (paddr == wwdt_pkg::ADDR_TC)
                tc_r <= (pwdata[23:0] < wwdt_pkg::TC_MIN)
                        ? wwdt_pkg::TC_MIN : pwdata[23:0];
            if (paddr == wwdt_pkg::ADDR_WARN)
                warn_r <= pwdata[9:0];
            if (paddr == wwdt_pkg::ADDR_WINDOW)
                window_r <= pwdata[23:0];
            if (paddr == wwdt_pkg::ADDR_CLKSEL && !en_r)
                clk_sel_r <= pwdata[0]; // Locked once running
        end
    end

    // ==========================================================
    // Feed sequence: first byte arms, second byte completes
    logic feed_wr;
    assign feed_wr = reg_wr(wr_en, paddr, wwdt_pkg::ADDR_FEED);
    assign feed_ok = feed_wr && feed_armed_r
                     && pwdata[7:0] == wwdt_pkg::FEED_SECOND;
    // Anything else to the feed register while armed breaks the sequence
    assign feed_bad = en_r && feed_wr && feed_armed_r
                      && pwdata[7:0] != wwdt_pkg::FEED_SECOND;
    assign feed_early = en_r && feed_ok && window_mode_r
                        && cnt_r > window_r;

    // Armed after the first byte; any further feed write disarms
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            feed_armed_r <= 1'b0;
        else if (feed_wr)
            feed_armed_r <= !feed_armed_r
                            && pwdata[7:0] == wwdt_pkg::FEED_FIRST;
    end

    // ==========================================================
    // Prescaler and 24-bit down-counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc_r <= 2'h0;
            cnt_r <= wwdt_pkg::TC_RESET;
        end
        else if (feed_ok && !feed_early)
        begin
            presc_r <= 2'h0;
            cnt_r <= tc_r;
        end
        else if (en_r && count_tick)
        begin
            presc_r <= presc_r + 2'h1; // Four counting clocks a count
            if (presc_r == wwdt_pkg::PRESCALE_LAST && cnt_r != 24'h000000)
                cnt_r <= cnt_r - 24'h000001;
        end
    end

    // Events last one pclk, on the fourth tick of the prescaler
    assign timeout_ev = en_r && count_tick && cnt_r == 24'h000000
                        && presc_r == wwdt_pkg::PRESCALE_LAST;
    assign warn_ev = en_r && count_tick && warn_r != 10'h000
                     && presc_r == wwdt_pkg::PRESCALE_LAST
                     && cnt_r == {14'h0000, warn_r};
    assign any_fault = timeout_ev | feed_bad | feed_early;

    // ==========================================================
    // Sticky status, write one to clear; set beats clear
    always_comb
    begin
        events = '0;
        events[wwdt_pkg::ST_TIMEOUT_BIT] = timeout_ev;
        events[wwdt_pkg::ST_WARN_BIT] = warn_ev;
        events[wwdt_pkg::ST_BADFEED_BIT] = feed_bad;
        events[wwdt_pkg::ST_EARLY_BIT] = feed_early;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_r <= '0;
        else if (reg_wr(wr_en, paddr, wwdt_pkg::ADDR_STATUS))
            status_r <= (status_r & ~pwdata[ST_W-1:0]) | events;
        else
            status_r <= status_r | events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_r <= '0;
        else if (reg_wr(wr_en, paddr, wwdt_pkg::ADDR_MASK))
            mask_r <= pwdata[ST_W-1:0];
    end

    // Level interrupt from any unmasked status bit, one pclk behind
    // the status flop; faults in reset response show here as well
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(status_r & mask_r);
    end

    // Chip reset request holds until the chip's reset clears us
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            chip_reset_req <= 1'b0;
        else if (any_fault && reset_mode_r)
            chip_reset_req <= 1'b1;
    end

    // ==========================================================
    // Read data, registered in the setup cycle for the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                wwdt_pkg::ADDR_MODE: prdata <= {28'h0000000, window_mode_r,
                    rcause_r, reset_mode_r, en_r};
                wwdt_pkg::ADDR_TC: prdata <= {8'h00, tc_r};
                wwdt_pkg::ADDR_TV: prdata <= {8'h00, cnt_r};
                wwdt_pkg::ADDR_CLKSEL: prdata <= {31'h00000000, clk_sel_r};
                wwdt_pkg::ADDR_WARN: prdata <= {22'h000000, warn_r};
                wwdt_pkg::ADDR_WINDOW: prdata <= {8'h00, window_r};
                wwdt_pkg::ADDR_STATUS: prdata <= {28'h0000000, status_r};
                wwdt_pkg::ADDR_MASK: prdata <= {28'h0000000, mask_r};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule : wwdt_top

// file: shared/wwdt_pkg.sv
/*
 * Package for the windowed watchdog: register offsets, field positions,
 * reset values and the feed sequence.
 * Assumes an APB slave with 32-bit data, one aligned word per register.
 */
package wwdt_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_TC = 8'h04;
    localparam logic [7:0] ADDR_FEED = 8'h08;
    localparam logic [7:0] ADDR_TV = 8'h0c;
    localparam logic [7:0] ADDR_CLKSEL = 8'h10;
    localparam logic [7:0] ADDR_WARN = 8'h14;
    localparam logic [7:0] ADDR_WINDOW = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_MASK = 8'h20;
    // ==========================================================
    // Mode register bit positions
    localparam int MODE_EN_BIT = 0;
    localparam int MODE_RESET_BIT = 1;
    localparam int MODE_RCAUSE_BIT = 2;
    localparam int MODE_WINDOW_BIT = 3;
    // Status register bit positions
    localparam int ST_TIMEOUT_BIT = 0;
    localparam int ST_WARN_BIT = 1;
    localparam int ST_BADFEED_BIT = 2;
    localparam int ST_EARLY_BIT = 3;
    localparam int ST_WIDTH = 4;
    // ==========================================================
    // Reset values and limits
    localparam logic [23:0] TC_RESET = 24'h0000ff;
    localparam logic [23:0] TC_MIN = 24'h0000ff;
    localparam logic [23:0] WINDOW_RESET = 24'hffffff;
    localparam logic [9:0] WARN_RESET = 10'h000;
    localparam logic [1:0] PRESCALE_LAST = 2'h3;
    // Feed sequence bytes
    localparam logic [7:0] FEED_FIRST = 8'haa;
    localparam logic [7:0] FEED_SECOND = 8'h55;
endpackage : wwdt_pkg

// file: sim/windowed_watchdog_timer_tb.sv
/*
 * Self-checking bench for wwdt_top: APB master tasks and scenarios.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/100ps
module windowed_watchdog_timer_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, crq, irq;
    logic rc_run = 1'b1, seen = 1'b0;
    logic [1:0] div_r = 2'h0;
    int mismatches = 0, tests_run = 0;
    // ==========================================================
    // Clock; both oscillators are four-cycle squares, RC can be stopped
    initial forever #5 pclk = ~pclk;
    always_ff @(posedge pclk) div_r <= div_r + 2'h1;
    wwdt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .internal_rc_oscillator(div_r[1] & rc_run),
        .dedicated_watchdog_oscillator(div_r[1]), .wdt_reset_seen(seen),
        .chip_reset_req(crq), .irq(irq));
    // ==========================================================
    // Shared tasks
    task complete_run();
        if (mismatches == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Setup, then access held until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rdc
    task feed(input logic [7:0] second);
        wr(wwdt_pkg::ADDR_FEED, {24'h0, wwdt_pkg::FEED_FIRST});
        wr(wwdt_pkg::ADDR_FEED, {24'h0, second});
    endtask : feed
    // Bounded wait; the counts stay well above the expected latency
    task wait_irq(input int n);
        for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge pclk);
        chk(32'(irq), 32'h1);
    endtask : wait_irq
    task do_reset(input logic s);
        @(posedge pclk);
        presetn <= 1'b0;
        seen <= s;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Cause level stands until it has passed the two sync flops
        repeat (3) @(posedge pclk);
        seen <= 1'b0;
    endtask : do_reset
    // ==========================================================
    // Scenarios
    task t_defaults();
        rdc(wwdt_pkg::ADDR_TC, 32'h000000ff);
        rdc(wwdt_pkg::ADDR_WINDOW, 32'h00ffffff);
        rdc(8'h24, 32'h0);
        wr(wwdt_pkg::ADDR_TC, 32'h00000010);
        rdc(wwdt_pkg::ADDR_TC, 32'h000000ff);
    endtask : t_defaults
    task t_badfeed();
        wr(wwdt_pkg::ADDR_MASK, 32'hf);
        wr(wwdt_pkg::ADDR_MODE, 32'h1);
        feed(8'h12);
        rdc(wwdt_pkg::ADDR_STATUS, 32'h4);
        chk(32'(irq), 32'h1);
        rdc(wwdt_pkg::ADDR_MODE, 32'h0);
        wr(wwdt_pkg::ADDR_STATUS, 32'h4);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0);
    endtask : t_badfeed
    // Warning, then time-out, both in interrupt response
    task t_warn();
        wr(wwdt_pkg::ADDR_WARN, 32'h80);
        wr(wwdt_pkg::ADDR_MASK, 32'h2);
        wr(wwdt_pkg::ADDR_MODE, 32'h1);
        wr(wwdt_pkg::ADDR_MODE, 32'h0);
        rdc(wwdt_pkg::ADDR_MODE, 32'h1);
        wait_irq(3000);
        rdc(wwdt_pkg::ADDR_STATUS, 32'h2);
        wr(wwdt_pkg::ADDR_STATUS, 32'h2);
        wr(wwdt_pkg::ADDR_MASK, 32'h1);
        wait_irq(3000);
        rdc(wwdt_pkg::ADDR_STATUS, 32'h1);
        rdc(wwdt_pkg::ADDR_MODE, 32'h0);
    endtask : t_warn
    task t_window();
        do_reset(1'b0);
        wr(wwdt_pkg::ADDR_TC, 32'h200);
        wr(wwdt_pkg::ADDR_MODE, 32'h1);
        feed(wwdt_pkg::FEED_SECOND);
        rdc(wwdt_pkg::ADDR_TV, 32'h200);
        wr(wwdt_pkg::ADDR_WINDOW, 32'h100);
        wr(wwdt_pkg::ADDR_MODE, 32'h9);
        feed(wwdt_pkg::FEED_SECOND);
        rdc(wwdt_pkg::ADDR_STATUS, 32'h8);
    endtask : t_window
    // RC stopped: only the watchdog oscillator can move the counter
    task t_clksel();
        do_reset(1'b0);
        rc_run <= 1'b0;
        wr(wwdt_pkg::ADDR_CLKSEL, 32'h1);
        rdc(wwdt_pkg::ADDR_CLKSEL, 32'h1);
        wr(wwdt_pkg::ADDR_MODE, 32'h1);
        repeat (200) @(posedge pclk);
        apb(1'b0, wwdt_pkg::ADDR_TV, 32'h0);
        chk(32'(q < 32'h000000ff), 32'h1);
        wr(wwdt_pkg::ADDR_CLKSEL, 32'h0);
        rdc(wwdt_pkg::ADDR_CLKSEL, 32'h1);
        rc_run <= 1'b1;
    endtask : t_clksel
    task t_cause();
        wr(wwdt_pkg::ADDR_MODE, 32'h3);
        feed(8'h00);
        repeat (2) @(posedge pclk);
        chk(32'(crq), 32'h1);
        do_reset(1'b1);
        chk(32'(crq), 32'h0);
        rdc(wwdt_pkg::ADDR_MODE, 32'h4);
        wr(wwdt_pkg::ADDR_MODE, 32'h4);
        rdc(wwdt_pkg::ADDR_MODE, 32'h0);
        // Missed reload in reset response: 256 counts of 16 pclk each
        wr(wwdt_pkg::ADDR_MODE, 32'h3);
        for (int i = 0; i < 4400 && crq !== 1'b1; i++) @(posedge pclk);
        chk(32'(crq), 32'h1);
        rdc(wwdt_pkg::ADDR_STATUS, 32'h1);
    endtask : t_cause
    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        do_reset(1'b0);
        t_defaults();
        t_badfeed();
        t_warn();
        t_window();
        t_clksel();
        t_cause();
        complete_run();
    end
    initial
    begin
        #200000;
        mismatches++;
        complete_run();
    end
endmodule : windowed_watchdog_timer_tb

// file: sim/wwdt_asserts.sv
/*
 * Checker on the ports of wwdt_top: bus answer, readback and fault pins.
 * Assumes one pclk domain with presetn as asynchronous active-low reset.
 */
`timescale 1ns/100ps
module wwdt_asserts
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chip_reset_req,
    input wire logic irq
);
    // ==========================================================
    // Read setup cycle; prdata is loaded at its closing edge
    logic rd_s;
    assign rd_s = psel && !penable && !pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Properties
    property p_rdy; psel |-> pready && !pslverr; endproperty
    a_rdy: assert property (p_rdy)
        else $error("bus answer not ready or error");
    property p_hold; psel && penable |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold)
        else $error("read data moved in access phase");
    property p_unmap;
        rd_s && paddr > wwdt_pkg::ADDR_MASK |=> prdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    property p_tc;
        rd_s && paddr == wwdt_pkg::ADDR_TC
            |=> prdata[31:24] == 8'h00 && prdata[23:0] >= wwdt_pkg::TC_MIN;
    endproperty
    a_tc: assert property (p_tc)
        else $error("time-out constant out of range");
    property p_tv; rd_s && paddr == wwdt_pkg::ADDR_TV |=> !(|prdata[31:24]);
    endproperty
    a_tv: assert property (p_tv)
        else $error("counter wider than 24 bits");
    property p_st;
        rd_s && paddr == wwdt_pkg::ADDR_STATUS |=> prdata[31:4] == 28'h0;
    endproperty
    a_st: assert property (p_st)
        else $error("status has stray bits");
    // Reset request is held until the chip reset arrives
    property p_crq; chip_reset_req |=> chip_reset_req; endproperty
    a_crq: assert property (p_crq)
        else $error("reset request dropped");
    // Clearing write lands at the access edge, irq drops one edge later
    property p_irqfall; $fell(irq) |-> $past(psel && penable && pwrite, 2);
    endproperty
    a_irqfall: assert property (p_irqfall)
        else $error("interrupt fell without a write");
    c_tv: cover property (rd_s && paddr == wwdt_pkg::ADDR_TV);
    c_crq: cover property ($rose(chip_reset_req));
    c_irq: cover property ($rose(irq));
endmodule : wwdt_asserts

bind wwdt_top wwdt_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_reset_req(chip_reset_req), .irq(irq));
